// ### design/fam_pkg.sv
// constants, register map and types for the freezer alarm manager
// assumes a 100 MHz core clock and sensor levels arriving as raw pins
package fam_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_MS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FLASH_PERIOD_MS = 250;
  localparam int FLASH_CYCLES = FLASH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SEC_PER_MIN = 60;

  // widths
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int TW = 9;
  localparam int TMRW = 14;
  localparam int NSENS = 9;
  localparam int NAL = 6;
  localparam int NSYNC = 25;

  // register byte offsets
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_THR1 = 8'h04;
  localparam logic [AW-1:0] ADDR_THR2 = 8'h08;
  localparam logic [AW-1:0] ADDR_CMD = 8'h0C;
  localparam logic [AW-1:0] ADDR_STAT = 8'h10;
  localparam logic [AW-1:0] ADDR_TCDIAG = 8'h14;
  localparam logic [AW-1:0] ADDR_SDSEL = 8'h18;
  localparam logic [AW-1:0] ADDR_SDRD = 8'h1C;
  localparam logic [AW-1:0] ADDR_CALICE = 8'h20;
  localparam logic [AW-1:0] ADDR_CALLN2 = 8'h24;

  // control register fields
  localparam int CTRL_RDLY_LSB = 0;
  localparam int CTRL_LOW_LSB = 3;
  localparam int CTRL_LID_LSB = 6;
  localparam int CTRL_SERR_EN = 9;
  localparam int CTRL_TCA_EN = 10;
  localparam int CTRL_STYPE_LSB = 11;
  localparam int CTRL_TC1_EN = 13;
  localparam int CTRL_TC2_EN = 14;
  localparam int SEL_W = 3;
  localparam int STYPE_W = 2;
  localparam logic [DW-1:0] CTRL_RST = 16'h2000;

  // threshold registers: enable bit and signed degrees C
  localparam int THR_EN_BIT = 15;
  localparam logic [DW-1:0] THR_RST = 16'h0000;
  localparam logic signed [TW-1:0] THR_MAX_C = 9'sd0;
  localparam logic signed [TW-1:0] THR_MIN_C = -9'sd190;

  // command register bits, write one to act
  localparam int CMD_MUTE = 0;
  localparam int CMD_STOPFILL = 1;
  localparam int CMD_T_AUD = 2;
  localparam int CMD_T_VIS = 3;
  localparam int CMD_T_REM = 4;
  localparam int CMD_T_END = 5;
  localparam int CMD_CAL_GO = 6;
  localparam int CMD_CAL_OK = 7;
  localparam int CMD_CAL_TC2 = 8;

  // status register fields
  localparam int STAT_MUTE = 8;
  localparam int STAT_VALVE = 9;
  localparam int STAT_RELAY = 10;
  localparam int STAT_CAL_LSB = 11;

  // tc self-check fields
  localparam int TCD_PRES1 = 0;
  localparam int TCD_OPEN1 = 1;
  localparam int TCD_PRES2 = 2;
  localparam int TCD_OPEN2 = 3;

  // alarm bit positions
  localparam int AL_HT1 = 0;
  localparam int AL_HT2 = 1;
  localparam int AL_LOW = 2;
  localparam int AL_SENS = 3;
  localparam int AL_LID = 4;
  localparam int AL_TCO = 5;

  // remote delay choices
  localparam logic [SEL_W-1:0] RD_NONE = 3'h0;
  localparam logic [SEL_W-1:0] RD_IMM = 3'h1;
  localparam logic [SEL_W-1:0] RD_30M = 3'h2;
  localparam logic [SEL_W-1:0] RD_60M = 3'h3;
  localparam logic [SEL_W-1:0] RD_2H = 3'h4;
  // low supply choices
  localparam logic [SEL_W-1:0] LS_NONE = 3'h0;
  localparam logic [SEL_W-1:0] LS_15M = 3'h1;
  localparam logic [SEL_W-1:0] LS_30M = 3'h2;
  localparam logic [SEL_W-1:0] LS_45M = 3'h3;
  localparam logic [SEL_W-1:0] LS_60M = 3'h4;
  localparam logic [SEL_W-1:0] LS_2H = 3'h5;
  localparam logic [SEL_W-1:0] LS_3H = 3'h6;
  // lid limit choices
  localparam logic [SEL_W-1:0] LID_NONE = 3'h0;
  localparam logic [SEL_W-1:0] LID_1M = 3'h1;
  localparam logic [SEL_W-1:0] LID_2M = 3'h2;
  localparam logic [SEL_W-1:0] LID_5M = 3'h3;
  localparam logic [SEL_W-1:0] LID_10M = 3'h4;

  // periods in minutes
  localparam int P_1_MIN = 1;
  localparam int P_2_MIN = 2;
  localparam int P_5_MIN = 5;
  localparam int P_10_MIN = 10;
  localparam int P_15_MIN = 15;
  localparam int P_30_MIN = 30;
  localparam int P_45_MIN = 45;
  localparam int P_60_MIN = 60;
  localparam int P_2_HOUR_MIN = 120;
  localparam int P_3_HOUR_MIN = 180;

  // sensor assembly types and diagnostics
  localparam logic [STYPE_W-1:0] ST_FOUR = 2'h0;
  localparam logic [STYPE_W-1:0] ST_EIGHT_TH = 2'h1;
  localparam logic [STYPE_W-1:0] ST_EIGHT_ARR = 2'h2;
  localparam logic [3:0] CNT_EIGHT = 4'h9;
  localparam logic [3:0] CNT_FOUR = 4'h4;
  localparam logic [3:0] UNPLUG_LEVEL_IN = 4'h8;
  localparam logic [7:0] CODE_OPEN = 8'h4F;
  localparam logic [7:0] CODE_GAS = 8'h47;
  localparam logic [7:0] CODE_LIQ = 8'h4C;

  // calibration points and acceptance window
  localparam logic signed [TW-1:0] ICE_POINT_C = 9'sd0;
  localparam logic signed [TW-1:0] LN2_POINT_C = -9'sd196;
  localparam logic signed [TW-1:0] CAL_TOL_C = 9'sd10;

  typedef enum logic [4:0] {
    CAL_IDLE = 5'h01,
    CAL_ICE = 5'h02,
    CAL_LN2 = 5'h04,
    CAL_DONE = 5'h08,
    CAL_FAIL = 5'h10
  } fam_cal_t;
endpackage

// ### design/fam_top.sv
// freezer alarm manager: alarms, remote relay, fill timer, diagnostics
// assumes temperatures come from a converter on i_clk; all other
// sensor, lid and valve signals are raw pins and are synchronised here
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module fam_top
  import fam_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES,
  parameter int FLASH_CNT = FLASH_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic signed [TW-1:0] i_tc1_temp,
  input wire logic signed [TW-1:0] i_tc2_temp,
  input wire logic i_tc1_open,
  input wire logic i_tc2_open,
  input wire logic i_lid_open,
  input wire logic [NSENS-1:0] i_sens_open,
  input wire logic [NSENS-1:0] i_sens_liquid,
  input wire logic i_sens_unplugged,
  input wire logic i_stop_level,
  input wire logic i_fill_start,
  input wire logic i_power_fail,
  output logic [DW-1:0] o_rd_data,
  output logic o_buzzer,
  output logic o_red_led,
  output logic o_relay_hold,
  output logic o_valve_open,
  output logic [NAL-1:0] o_disp_err,
  output logic [3:0] o_level_in,
  output logic o_level_high_alarm
);

  // period lookups: bit TMRW set means the choice is enabled
  function automatic logic [TMRW:0] mins(input int m);
    mins = {1'b1, TMRW'(m * SEC_PER_MIN)};
  endfunction

  function automatic logic [TMRW:0] rdly_sec(input logic [SEL_W-1:0] s);
    unique case (s)
      RD_IMM: rdly_sec = {1'b1, {TMRW{1'b0}}};
      RD_30M: rdly_sec = mins(P_30_MIN);
      RD_60M: rdly_sec = mins(P_60_MIN);
      RD_2H: rdly_sec = mins(P_2_HOUR_MIN);
      default: rdly_sec = '0; // none and unused codes
    endcase
  endfunction

  function automatic logic [TMRW:0] low_sec(input logic [SEL_W-1:0] s);
    unique case (s)
      LS_15M: low_sec = mins(P_15_MIN);
      LS_30M: low_sec = mins(P_30_MIN);
      LS_45M: low_sec = mins(P_45_MIN);
      LS_60M: low_sec = mins(P_60_MIN);
      LS_2H: low_sec = mins(P_2_HOUR_MIN);
      LS_3H: low_sec = mins(P_3_HOUR_MIN);
      default: low_sec = '0;
    endcase
  endfunction

  function automatic logic [TMRW:0] lid_sec(input logic [SEL_W-1:0] s);
    unique case (s)
      LID_1M: lid_sec = mins(P_1_MIN);
      LID_2M: lid_sec = mins(P_2_MIN);
      LID_5M: lid_sec = mins(P_5_MIN);
      LID_10M: lid_sec = mins(P_10_MIN);
      default: lid_sec = '0;
    endcase
  endfunction

  // saturating one-second counter that clears with its condition
  function automatic logic [TMRW-1:0] sec_step(input logic [TMRW-1:0] c,
                                               input logic run,
                                               input logic tick);
    if (!run) begin
      sec_step = '0;
    end else if (tick && c != {TMRW{1'b1}}) begin
      sec_step = c + TMRW'(1);
    end else begin
      sec_step = c;
    end
  endfunction

  // threshold writes are held inside the programmable range
  function automatic logic signed [TW-1:0] clamp(input logic [TW-1:0] v);
    if ($signed(v) > THR_MAX_C) begin
      clamp = THR_MAX_C;
    end else if ($signed(v) < THR_MIN_C) begin
      clamp = THR_MIN_C;
    end else begin
      clamp = $signed(v);
    end
  endfunction

  function automatic logic near(input logic signed [TW-1:0] v,
                                input logic signed [TW-1:0] p);
    near = (v >= p - CAL_TOL_C) && (v <= p + CAL_TOL_C);
  endfunction

  logic [NSYNC-1:0] sync1_q, sync2_q;
  logic lid_s, tc1_open_s, tc2_open_s, unplug_s, stop_s, fill_s, pfail_s;
  logic [NSENS-1:0] sopen_s, sliq_s;
  logic fill_prev_q;
  logic [31:0] tick_cnt_q, flash_cnt_q;
  logic tick_q, flash_q;
  logic [DW-1:0] ctrl_q;
  logic thr1_en_q, thr2_en_q;
  logic signed [TW-1:0] thr1_q, thr2_q;
  logic [3:0] sdsel_q;
  logic [TMRW-1:0] lid_cnt_q, low_cnt_q, age_cnt_q;
  logic valve_q, low_al_q, mute_q;
  logic [NAL-1:0] alarm_q, alarm_d;
  logic tst_aud_q, tst_vis_q, tst_rem_q;
  fam_cal_t cal_q;
  logic cal_tc2_q;
  logic signed [TW-1:0] cal_ice_q, cal_ln2_q, cal_temp;
  logic [DW-1:0] rd_d;
  logic wr_cmd;
  logic [SEL_W-1:0] sel_rdly, sel_low, sel_lid;
  logic [STYPE_W-1:0] stype;
  logic [3:0] scount, liq_cnt;
  logic [NSENS-1:0] smask;
  logic [TMRW:0] rdly, lowp, lidp;
  logic any_err, relay_act;

  // two-stage synchronisers; only the second stage is read below
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (i_ce) begin
      sync1_q <= {i_lid_open, i_tc1_open, i_tc2_open, i_sens_open,
                  i_sens_liquid, i_sens_unplugged, i_stop_level,
                  i_fill_start, i_power_fail};
      sync2_q <= sync1_q;
    end
  end

  assign {lid_s, tc1_open_s, tc2_open_s, sopen_s, sliq_s, unplug_s,
          stop_s, fill_s, pfail_s} = sync2_q;

  // configuration fields
  assign sel_rdly = ctrl_q[CTRL_RDLY_LSB +: SEL_W];
  assign sel_low = ctrl_q[CTRL_LOW_LSB +: SEL_W];
  assign sel_lid = ctrl_q[CTRL_LID_LSB +: SEL_W];
  assign stype = ctrl_q[CTRL_STYPE_LSB +: STYPE_W];
  assign rdly = rdly_sec(sel_rdly);
  assign lowp = low_sec(sel_low);
  assign lidp = lid_sec(sel_lid);
  assign wr_cmd = i_wr && i_addr == ADDR_CMD;

  // both eight-sensor types list nine entries, the four-type four
  assign scount = (stype == ST_FOUR) ? CNT_FOUR : CNT_EIGHT;
  assign smask = NSENS'((1 << scount) - 1);

  // one-second time base and the red flash rate
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (i_ce) begin
      tick_q <= tick_cnt_q == 32'(TICK_CNT - 1);
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CNT - 1)) ? '0 :
                    tick_cnt_q + 32'h1;
      if (flash_cnt_q == 32'(FLASH_CNT - 1)) begin
        flash_cnt_q <= '0;
        flash_q <= ~flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 32'h1;
      end
    end
  end

  // register writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= CTRL_RST;
      thr1_en_q <= THR_RST[THR_EN_BIT];
      thr2_en_q <= THR_RST[THR_EN_BIT];
      thr1_q <= THR_RST[TW-1:0];
      thr2_q <= THR_RST[TW-1:0];
      sdsel_q <= '0;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        ADDR_CTRL: ctrl_q <= i_wdata;
        ADDR_THR1: begin
          thr1_en_q <= i_wdata[THR_EN_BIT];
          thr1_q <= clamp(i_wdata[TW-1:0]);
        end
        ADDR_THR2: begin
          thr2_en_q <= i_wdata[THR_EN_BIT];
          thr2_q <= clamp(i_wdata[TW-1:0]);
        end
        ADDR_SDSEL: sdsel_q <= i_wdata[3:0];
        default: ;
      endcase
    end
  end

  // fill valve: a stop in the same cycle as a start wins for safety
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valve_q <= 1'b0;
      fill_prev_q <= 1'b0;
    end else if (i_ce) begin
      fill_prev_q <= fill_s;
      if (stop_s || (wr_cmd && i_wdata[CMD_STOPFILL])) begin
        valve_q <= 1'b0;
      end else if (fill_s && !fill_prev_q) begin
        valve_q <= 1'b1;
      end
    end
  end

  assign o_valve_open = valve_q;

  // alarm delay timers, each cleared when its condition goes away
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lid_cnt_q <= '0;
      low_cnt_q <= '0;
      age_cnt_q <= '0;
    end else if (i_ce) begin
      lid_cnt_q <= sec_step(lid_cnt_q, lid_s, tick_q);
      low_cnt_q <= sec_step(low_cnt_q, valve_q, tick_q);
      age_cnt_q <= sec_step(age_cnt_q, any_err, tick_q);
    end
  end

  // low supply latches until the valve has closed
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_al_q <= 1'b0;
    end else if (i_ce) begin
      if (!valve_q) begin
        low_al_q <= 1'b0;
      end else if (lowp[TMRW] && low_cnt_q >= lowp[TMRW-1:0]) begin
        low_al_q <= 1'b1;
      end
    end
  end

  // alarm conditions; disabled thermocouples cannot raise open alarms
  always_comb begin
    alarm_d = '0;
    alarm_d[AL_HT1] = thr1_en_q && ctrl_q[CTRL_TC1_EN] &&
                      i_tc1_temp > thr1_q;
    alarm_d[AL_HT2] = thr2_en_q && ctrl_q[CTRL_TC2_EN] &&
                      i_tc2_temp > thr2_q;
    alarm_d[AL_LOW] = low_al_q;
    alarm_d[AL_SENS] = ctrl_q[CTRL_SERR_EN] &&
                       (unplug_s || |(sopen_s & smask));
    alarm_d[AL_LID] = lidp[TMRW] && lid_s &&
                      lid_cnt_q >= lidp[TMRW-1:0];
    alarm_d[AL_TCO] = ctrl_q[CTRL_TCA_EN] &&
                      ((ctrl_q[CTRL_TC1_EN] && tc1_open_s) ||
                       (ctrl_q[CTRL_TC2_EN] && tc2_open_s));
  end

  assign any_err = |alarm_q;

  // alarm state and mute; a fresh error beats a mute in the same cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alarm_q <= '0;
      mute_q <= 1'b0;
    end else if (i_ce) begin
      alarm_q <= alarm_d;
      if (|(alarm_d & ~alarm_q)) begin
        mute_q <= 1'b0;
      end else if (wr_cmd && i_wdata[CMD_MUTE]) begin
        mute_q <= 1'b1;
      end
    end
  end

  // user alarm tests run until an end-test command
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tst_aud_q <= 1'b0;
      tst_vis_q <= 1'b0;
      tst_rem_q <= 1'b0;
    end else if (i_ce && wr_cmd) begin
      if (i_wdata[CMD_T_END]) begin
        tst_aud_q <= 1'b0;
        tst_vis_q <= 1'b0;
        tst_rem_q <= 1'b0;
      end else begin
        tst_aud_q <= tst_aud_q | i_wdata[CMD_T_AUD];
        tst_vis_q <= tst_vis_q | i_wdata[CMD_T_VIS];
        tst_rem_q <= tst_rem_q | i_wdata[CMD_T_REM];
      end
    end
  end

  // relay fires when the error outlives the delay, on test, or on
  // power fail; the idle hold is dropped so a dead supply also trips it
  assign relay_act = pfail_s || tst_rem_q ||
                     (any_err && rdly[TMRW] &&
                      age_cnt_q >= rdly[TMRW-1:0]);

  // indicator outputs
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_buzzer <= 1'b0;
      o_red_led <= 1'b0;
      o_relay_hold <= 1'b0;
      o_disp_err <= '0;
    end else if (i_ce) begin
      // chirp for the test uses the flash rate to gate the sound
      o_buzzer <= (any_err && !mute_q) ||
                  (tst_aud_q && flash_q);
      o_red_led <= (any_err || tst_vis_q) && flash_q;
      o_relay_hold <= !relay_act;
      o_disp_err <= alarm_q;
    end
  end

  // level report from liquid-covered sensors
  always_comb begin
    liq_cnt = '0;
    for (int k = 0; k < NSENS; k++) begin
      liq_cnt = liq_cnt + 4'(sliq_s[k] & smask[k]);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_level_in <= '0;
      o_level_high_alarm <= 1'b0;
    end else if (i_ce) begin
      // an open assembly looks like deep liquid to the thermistors
      o_level_in <= (unplug_s && stype != ST_FOUR) ? UNPLUG_LEVEL_IN :
                    liq_cnt;
      o_level_high_alarm <= stype == ST_FOUR &&
                            (unplug_s || liq_cnt == CNT_FOUR);
    end
  end

  // calibration sequence
  assign cal_temp = cal_tc2_q ? i_tc2_temp : i_tc1_temp;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cal_q <= CAL_IDLE;
      cal_tc2_q <= 1'b0;
      cal_ice_q <= ICE_POINT_C;
      cal_ln2_q <= LN2_POINT_C;
    end else if (i_ce && wr_cmd) begin
      if (i_wdata[CMD_CAL_GO]) begin
        cal_q <= CAL_ICE;
        cal_tc2_q <= i_wdata[CMD_CAL_TC2];
      end else if (i_wdata[CMD_CAL_OK]) begin
        unique case (cal_q)
          CAL_ICE: begin
            cal_ice_q <= cal_temp;
            cal_q <= CAL_LN2;
          end
          CAL_LN2: begin
            cal_ln2_q <= cal_temp;
            cal_q <= (near(cal_ice_q, ICE_POINT_C) &&
                      near(cal_temp, LN2_POINT_C)) ? CAL_DONE : CAL_FAIL;
          end
          default: ; // confirm outside a capture step is ignored
        endcase
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_d = '0;
    unique case (i_addr)
      ADDR_CTRL: rd_d = ctrl_q;
      ADDR_THR1: rd_d = {thr1_en_q, (DW-1-TW)'(0), thr1_q};
      ADDR_THR2: rd_d = {thr2_en_q, (DW-1-TW)'(0), thr2_q};
      ADDR_STAT: begin
        rd_d[NAL-1:0] = alarm_q;
        rd_d[STAT_MUTE] = mute_q;
        rd_d[STAT_VALVE] = valve_q;
        rd_d[STAT_RELAY] = !o_relay_hold;
        rd_d[STAT_CAL_LSB +: 5] = cal_q;
      end
      ADDR_TCDIAG: begin
        // disabled thermocouples are left out of the report
        rd_d[TCD_PRES1] = ctrl_q[CTRL_TC1_EN];
        rd_d[TCD_OPEN1] = ctrl_q[CTRL_TC1_EN] && tc1_open_s;
        rd_d[TCD_PRES2] = ctrl_q[CTRL_TC2_EN];
        rd_d[TCD_OPEN2] = ctrl_q[CTRL_TC2_EN] && tc2_open_s;
      end
      ADDR_SDSEL: rd_d[3:0] = sdsel_q;
      ADDR_SDRD: begin
        rd_d[15:12] = scount;
        rd_d[11:8] = sdsel_q;
        if (sdsel_q < scount) begin
          rd_d[7:0] = sopen_s[sdsel_q] ? CODE_OPEN :
                      sliq_s[sdsel_q] ? CODE_LIQ : CODE_GAS;
        end
      end
      ADDR_CALICE: rd_d = DW'($signed(cal_ice_q));
      ADDR_CALLN2: rd_d = DW'($signed(cal_ln2_q));
      default: rd_d = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= '0;
    end else if (i_ce) begin
      o_rd_data <= i_rd ? rd_d : '0;
    end
  end

endmodule

// ### verification/fam_assertions.sv
// port checks for the freezer alarm manager
// bound to fam_top; bench keeps i_ce high and mutes once, after the first temperature alarm
`timescale 1ns/1ps
module fam_assertions
  import fam_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_lid_open,
  input wire logic i_sens_unplugged,
  input wire logic i_power_fail,
  input wire logic [DW-1:0] o_rd_data,
  input wire logic o_buzzer,
  input wire logic o_red_led,
  input wire logic o_relay_hold,
  input wire logic [NAL-1:0] o_disp_err,
  input wire logic [3:0] o_level_in,
  input wire logic o_level_high_alarm
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [3:0] dark_q;
  // dark time with an error shown; one flash half is four cycles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dark_q <= 4'h0;
    end else if (|o_disp_err && !o_red_led) begin
      dark_q <= dark_q + 4'h1;
    end else begin
      dark_q <= 4'h0;
    end
  end
  property p_buzz; i_ce && |(o_disp_err & ~$past(o_disp_err)) |-> ##[0:2] o_buzzer; endproperty
  a_buzz: assert property (p_buzz) else $error("no buzz on new alarm");
  property p_red; dark_q <= 4'hA; endproperty
  a_red: assert property (p_red) else $error("red lamp not flashing");
  property p_fail; i_ce && $rose(i_power_fail) |-> ##[1:4] !o_relay_hold; endproperty
  a_fail: assert property (p_fail) else $error("relay kept at rest");
  property p_lid; i_lid_open[*4] ##0 o_disp_err[AL_LID] |=> o_disp_err[AL_LID]; endproperty
  a_lid: assert property (p_lid) else $error("lid alarm dropped");
  property p_unplug; i_sens_unplugged[*6] |-> o_level_in == UNPLUG_LEVEL_IN || o_level_high_alarm; endproperty
  a_unplug: assert property (p_unplug) else $error("bad unplugged level");
  property p_mute; i_ce && i_wr && i_addr == ADDR_CMD && i_wdata[CMD_MUTE] && $stable(o_disp_err) |-> ##[2:3] !o_buzzer; endproperty
  a_mute: assert property (p_mute) else $error("mute ignored");
  property p_rdz; !(i_rd && i_ce) |=> o_rd_data == 16'h0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
  property p_unm; i_rd && i_ce && i_addr == 8'h3C |=> o_rd_data == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
bind fam_top fam_assertions u_fam_assertions (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_lid_open(i_lid_open),
  .i_sens_unplugged(i_sens_unplugged), .i_power_fail(i_power_fail),
  .o_rd_data(o_rd_data), .o_buzzer(o_buzzer), .o_red_led(o_red_led),
  .o_relay_hold(o_relay_hold), .o_disp_err(o_disp_err),
  .o_level_in(o_level_in), .o_level_high_alarm(o_level_high_alarm));

// ### verification/fam_far.sv
// far side model: nitrogen supply and the stop-fill level sensor
// assumes the bench raises the fill request; one clock, async reset
`timescale 1ns/1ps
module fam_far #(
  parameter int FILL_CYC = 40
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_fill_req,
  input wire logic i_supply_ok,
  output logic o_fill_start,
  output logic o_stop_level
);
  int cnt;
  // liquid climbs only while supply lasts, so an empty supply never stops
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 0;
    end else if (!i_fill_req || !i_supply_ok) begin
      cnt <= 0;
    end else if (cnt < FILL_CYC) begin
      cnt <= cnt + 1;
    end
  end
  assign o_fill_start = i_fill_req;
  assign o_stop_level = (cnt == FILL_CYC);
endmodule

// ### verification/fam_top_test.sv
// self-checking bench for the freezer alarm manager
// drives register port and pins; fam_far answers fills
`timescale 1ns/1ps
module fam_top_test
  import fam_pkg::*;
;
  logic i_clk = 1'b0, arst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic o1 = 1'b0, lid = 1'b0, unp = 1'b0, pf = 1'b0, freq = 1'b0;
  logic sup = 1'b1, fill, stop, buz, red, hold, lha, vo;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rv, rdd;
  logic signed [8:0] t1 = -9'sd150, t2 = -9'sd150;
  logic [8:0] sop = 9'h000, sliq = 9'h000;
  logic [5:0] derr;
  logic [3:0] lvl;
  logic [1:0] acc;
  int n_fail = 0, comparisons = 0;
  logic [2:0] rdly [3] = '{RD_NONE, RD_IMM, RD_30M};
  int rwait [3] = '{200, 20, 17900};
  logic [15:0] rhold [3] = '{16'h0001, 16'h0000, 16'h0001};
  logic [15:0] sdsel [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};
  logic [15:0] sdexp [4] = '{16'h404F, 16'h414C, 16'h4247, 16'h4400};
  always #5 i_clk = ~i_clk;
  // short tick and flash counts keep timer waits within the run
  fam_top #(.TICK_CNT(10), .FLASH_CNT(4)) u_fam_top (.i_clk(i_clk),
    .i_arst_n(arst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .i_tc1_temp(t1), .i_tc2_temp(t2),
    .i_tc1_open(o1), .i_tc2_open(1'b0), .i_lid_open(lid),
    .i_sens_open(sop), .i_sens_liquid(sliq), .i_sens_unplugged(unp),
    .i_stop_level(stop), .i_fill_start(fill), .i_power_fail(pf),
    .o_rd_data(rdd), .o_buzzer(buz), .o_red_led(red), .o_relay_hold(hold),
    .o_valve_open(vo), .o_disp_err(derr), .o_level_in(lvl),
    .o_level_high_alarm(lha));
  fam_far u_fam_far (.i_clk(i_clk), .i_arst_n(arst_n), .i_fill_req(freq),
    .i_supply_ok(sup), .o_fill_start(fill), .o_stop_level(stop));
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk) addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge i_clk) wr_s <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk) addr <= a;
    rd_s <= 1'b1;
    @(posedge i_clk) rd_s <= 1'b0;
    #1 rv = rdd;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic final_report();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    arst_n <= 1'b1;
    rd(ADDR_CTRL);
    chk(rv, CTRL_RST);
    rd(ADDR_STAT);
    chk(rv, 16'h0800);
    rd(8'h3C);
    chk(rv, 16'h0000);
    // tc1 at -100 C; tc2 stays disabled even though it is hot
    wr(ADDR_THR1, 16'h819C);
    @(posedge i_clk) t1 <= -9'sd90;
    t2 <= -9'sd10;
    cyc(5);
    chk(16'(derr), 16'h0001);
    chk(16'(buz), 16'h0001);
    wr(ADDR_CMD, 16'h0001);
    cyc(3);
    chk(16'(buz), 16'h0000);
    wr(ADDR_CTRL, 16'h6000);
    wr(ADDR_THR2, 16'h81CE);
    cyc(5);
    chk(16'(derr), 16'h0003);
    chk(16'(buz), 16'h0001);
    @(posedge i_clk) t1 <= -9'sd150;
    t2 <= -9'sd150;
    cyc(5);
    chk(16'(derr), 16'h0000);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL, CTRL_RST | {13'h0000, rdly[k]});
      @(posedge i_clk) t1 <= -9'sd90;
      cyc(rwait[k]);
      chk(16'(hold), rhold[k]);
      if (k == 2) begin
        cyc(300);
        chk(16'(hold), 16'h0000);
      end
      @(posedge i_clk) t1 <= -9'sd150;
      cyc(20);
      chk(16'(hold), 16'h0001);
    end
    @(posedge i_clk) pf <= 1'b1;
    cyc(6);
    chk(16'(hold), 16'h0000);
    @(posedge i_clk) pf <= 1'b0;
    wr(ADDR_CMD, 16'h001C);
    acc = 2'b00;
    repeat (10) begin
      cyc(1);
      acc |= {buz, red};
    end
    chk(16'(acc), 16'h0003);
    chk(16'(hold), 16'h0000);
    wr(ADDR_CMD, 16'h0020);
    cyc(6);
    chk(16'(hold), 16'h0001);
    // lid limit of one minute; closing in between restarts the count
    wr(ADDR_CTRL, 16'h2040);
    @(posedge i_clk) lid <= 1'b1;
    cyc(500);
    @(posedge i_clk) lid <= 1'b0;
    cyc(5);
    @(posedge i_clk) lid <= 1'b1;
    cyc(580);
    chk(16'(derr), 16'h0000);
    cyc(40);
    chk(16'(derr), 16'h0010);
    @(posedge i_clk) lid <= 1'b0;
    cyc(5);
    chk(16'(derr), 16'h0000);
    wr(ADDR_CTRL, 16'h2008);
    @(posedge i_clk) freq <= 1'b1;
    cyc(10);
    rd(ADDR_STAT);
    chk(16'({rv[9], vo}), 16'h0003);
    cyc(60);
    rd(ADDR_STAT);
    chk(16'({rv[9], vo}), 16'h0000);
    @(posedge i_clk) freq <= 1'b0;
    sup <= 1'b0;
    cyc(3);
    @(posedge i_clk) freq <= 1'b1;
    cyc(10);
    wr(ADDR_CMD, 16'h0002);
    rd(ADDR_STAT);
    chk(rv & 16'h0200, 16'h0000);
    @(posedge i_clk) freq <= 1'b0;
    cyc(3);
    @(posedge i_clk) freq <= 1'b1;
    cyc(8900);
    chk(16'(derr), 16'h0000);
    cyc(300);
    chk(16'(derr), 16'h0004);
    @(posedge i_clk) sup <= 1'b1;
    cyc(60);
    chk(16'(derr), 16'h0000);
    @(posedge i_clk) freq <= 1'b0;
    sop <= 9'h001;
    sliq <= 9'h002;
    wr(ADDR_CTRL, 16'h2000);
    cyc(6);
    chk(16'(derr), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SDSEL, sdsel[k]);
      rd(ADDR_SDRD);
      chk(rv, sdexp[k]);
    end
    wr(ADDR_CTRL, 16'h2A00);
    wr(ADDR_SDSEL, 16'h0008);
    rd(ADDR_SDRD);
    chk(rv, 16'h9847);
    chk(16'(derr), 16'h0008);
    @(posedge i_clk) sop <= 9'h000;
    unp <= 1'b1;
    cyc(8);
    chk(16'(lvl), 16'h0008);
    chk(16'(derr), 16'h0008);
    @(posedge i_clk) unp <= 1'b0;
    wr(ADDR_CTRL, 16'h2400);
    @(posedge i_clk) o1 <= 1'b1;
    cyc(6);
    chk(16'(derr), 16'h0020);
    rd(ADDR_TCDIAG);
    chk(rv, 16'h0003);
    @(posedge i_clk) o1 <= 1'b0;
    // calibration walks ice, then nitrogen, then done
    wr(ADDR_CMD, 16'h0040);
    rd(ADDR_STAT);
    chk(rv & 16'hF800, 16'h1000);
    @(posedge i_clk) t1 <= 9'sd2;
    cyc(4);
    wr(ADDR_CMD, 16'h0080);
    rd(ADDR_STAT);
    chk(rv & 16'hF800, 16'h2000);
    @(posedge i_clk) t1 <= -9'sd195;
    cyc(4);
    wr(ADDR_CMD, 16'h0080);
    rd(ADDR_STAT);
    chk(rv & 16'hF800, 16'h4000);
    rd(ADDR_CALICE);
    chk(rv & 16'h01FF, 16'h0002);
    final_report();
  end
endmodule
